// ===== rtl/pwm_prot_out.sv
// Fault, current-limit, blanking, override and output conditioning of one PWM generator
//
// Summary of operation
// - Swap control exchanges high and low signals
// - Override data applies at time base or immediately
// - Counter match with compare value triggers ADC
// - Current-limit selector maps faults and comparators
// - Fault selector same codes, resets to fault 32
// - Current-limit polarity selects active-low or active-high
// - Current limit acts only when enabled
// - Fault polarity selects active-low or active-high
// - Fault mode 11 disables, 10 reserved
// - Cycle mode forces pins while fault active
// - Latched mode holds forced pins after fault
// - Lock bit rejects I/O and fault control writes without unlock
// - Enabled output edges restart blanking counter
// - Separate edge blanking enables for fault, limit
// - State blanking on own output levels
// - Blank source selector: none or generators 1-3
// - Twelve-bit delay sets edge blanking length
// - Fault drives pins to fault data bits
// - Current limit drives pins to limit data bits
module pwm_prot_out
	import pwm_prot_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DW-1:0] rdata_o,
	input wire logic pwm_write_lock_cfg_i,
	input wire logic gen_high_i,
	input wire logic gen_low_i,
	input wire logic period_start_i,
	input wire logic local_tb_i,
	input wire logic [DW-1:0] tb_count_i,
	input wire logic [2:0] peer_high_i,
	input wire logic [SRC_W-1:0] prot_src_i,
	output logic high_side_output_o,
	output logic low_side_output_o,
	output logic adc_trigger_o,
	output logic fault_active_o,
	output logic limit_active_o
);
	typedef enum logic [1:0] {UL_IDLE, UL_KEY, UL_OPEN} unlock_t;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [DW-1:0] io_q, io_d, trig_q, trig_d, fcl_q, fcl_d;
	logic [DW-1:0] leb_q, leb_d, dly_q, dly_d, aux_q, aux_d, rdata_q, rdata_d;
	unlock_t ul_q, ul_d;
	logic lock_ok, fcl_wr;
	logic flt_qual, cl_qual, latch_q, latch_d;
	logic [LEB_W-1:0] cnt_q, cnt_d;

	assign lock_ok = !pwm_write_lock_cfg_i || (ul_q == UL_OPEN);

	// Decode writes, unlock sequence and reads
	always_comb
	begin
		io_d = io_q;
		trig_d = trig_q;
		fcl_d = fcl_q;
		leb_d = leb_q;
		dly_d = dly_q;
		aux_d = aux_q;
		ul_d = ul_q;
		fcl_wr = 1'b0;
		rdata_d = ZERO_RST;
		if (wr_i)
		begin
			if (ul_q == UL_KEY && addr_i == OFS_UNLOCK && wdata_i == KEY_B)
				ul_d = UL_OPEN;
			else if (ul_q == UL_KEY && !(addr_i == OFS_UNLOCK && wdata_i == KEY_A))
				ul_d = UL_IDLE;
			else if (addr_i == OFS_UNLOCK && wdata_i == KEY_A)
				ul_d = UL_KEY;
			unique case (addr_i)
				OFS_IO:
				begin
					if (lock_ok)
						io_d = wdata_i;
					ul_d = UL_IDLE;
				end
				OFS_FCL:
				begin
					if (lock_ok)
					begin
						fcl_d = wdata_i & FCL_MASK;
						fcl_wr = 1'b1;
					end
					ul_d = UL_IDLE;
				end
				OFS_TRIG: trig_d = wdata_i;
				OFS_LEB: leb_d = wdata_i & LEB_MASK;
				OFS_DLY: dly_d = wdata_i & DLY_MASK;
				OFS_AUX: aux_d = wdata_i & AUX_MASK;
				default: ;
			endcase
		end
		if (rd_i)
		begin
			unique case (addr_i)
				OFS_IO: rdata_d = io_q;
				OFS_TRIG: rdata_d = trig_q;
				OFS_FCL: rdata_d = fcl_q;
				OFS_LEB: rdata_d = leb_q;
				OFS_DLY: rdata_d = dly_q;
				OFS_AUX: rdata_d = aux_q;
				OFS_STAT: rdata_d = {12'h000, ul_q == UL_OPEN, cnt_q != '0, cl_qual,
					flt_qual | latch_q};
				default: rdata_d = ZERO_RST;
			endcase
		end
	end

	// Register state
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			io_q <= IO_RST;
			trig_q <= ZERO_RST;
			fcl_q <= FCL_RST;
			leb_q <= ZERO_RST;
			dly_q <= ZERO_RST;
			aux_q <= ZERO_RST;
			ul_q <= UL_IDLE;
			rdata_q <= ZERO_RST;
		end
		else if (ce_i)
		begin
			io_q <= io_d;
			trig_q <= trig_d;
			fcl_q <= fcl_d;
			leb_q <= leb_d;
			dly_q <= dly_d;
			aux_q <= aux_d;
			ul_q <= ul_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------
	// Protection path
	// ----------------------------------------
	logic [SRC_W-1:0] src_m_q, src_s_q;
	logic [3:0] ovr_q, ovr_d;
	logic pre_h, pre_l, prev_h_q, prev_l_q, edge_hit, leb_on;
	logic blank_sel, state_blank, flt_raw, cl_raw, flt_on, cl_on;
	logic out_h_d, out_l_d, out_h_q, out_l_q, trig_d_o, trig_q_o;
	logic [1:0] fmode;
	logic [3:0] bsel;

	assign fmode = fcl_q[FCL_FAULT_MODE_SEL+:2];
	assign bsel = aux_q[AUX_STATE_BLANK_SOURCE_SEL+:4];

	// Generator signals after exchange
	assign pre_h = io_q[IO_SWAP] ? gen_low_i : gen_high_i;
	assign pre_l = io_q[IO_SWAP] ? gen_high_i : gen_low_i;

	// Blanking, qualification and output selection
	always_comb
	begin
		ovr_d = ovr_q;
		if (!io_q[IO_OVERRIDE_SYNC_SEL] || period_start_i)
			ovr_d = {io_q[IO_OVRENH], io_q[IO_OVRENL], io_q[IO_OVERRIDE_PIN_STATES_H], io_q[IO_OVERRIDE_PIN_STATES_L]};
		edge_hit = (leb_q[LEB_PHR] && pre_h && !prev_h_q)
			|| (leb_q[LEB_PHF] && !pre_h && prev_h_q)
			|| (leb_q[LEB_PLR] && pre_l && !prev_l_q)
			|| (leb_q[LEB_PLF] && !pre_l && prev_l_q);
		if (edge_hit)
			cnt_d = dly_q[LEB_W-1:0];
		else if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
		else
			cnt_d = cnt_q;
		leb_on = cnt_q != '0;
		blank_sel = 1'b0;
		if (bsel != BLANK_NONE && bsel <= BLANK_LAST)
			blank_sel = peer_high_i[bsel[1:0] - 2'h1];
		state_blank = (bsel != BLANK_NONE && bsel <= BLANK_LAST
			&& ((leb_q[LEB_BCH] && blank_sel) || (leb_q[LEB_BCL] && !blank_sel)))
			|| (leb_q[LEB_BLANK_WHEN_HI_OUT_HIGH] && pre_h) || (leb_q[LEB_BLANK_WHEN_HI_OUT_LOW] && !pre_h)
			|| (leb_q[LEB_BLANK_WHEN_LO_OUT_HIGH] && pre_l) || (leb_q[LEB_BLANK_WHEN_LO_OUT_LOW] && !pre_l);
		flt_raw = src_pick(fcl_q[FCL_FAULT_SOURCE_SEL+:5], src_s_q) ^ fcl_q[FCL_FAULT_POLARITY];
		cl_raw = src_pick(fcl_q[FCL_CURRENT_LIMIT_SOURCE_SEL+:5], src_s_q) ^ fcl_q[FCL_CURRENT_LIMIT_POLARITY];
		if (!(fcl_q[FCL_FAULT_SOURCE_SEL+:5] inside {[5'h00:SRC_LAST_COMP], SRC_FAULT32}))
			flt_raw = 1'b0;
		if (!(fcl_q[FCL_CURRENT_LIMIT_SOURCE_SEL+:5] inside {[5'h00:SRC_LAST_COMP], SRC_FAULT32}))
			cl_raw = 1'b0;
		flt_qual = flt_raw && !state_blank && !(leb_on && leb_q[LEB_FLTEN])
			&& (fmode == FLT_LATCHED || fmode == FLT_CYCLE);
		cl_qual = cl_raw && fcl_q[FCL_CURRENT_LIMIT_ENABLE] && !state_blank
			&& !(leb_on && leb_q[LEB_CLEN]);
		latch_d = latch_q;
		if (fcl_wr || fmode != FLT_LATCHED)
			latch_d = 1'b0;
		if (flt_qual && fmode == FLT_LATCHED)
			latch_d = 1'b1;
		flt_on = flt_qual || latch_q;
		cl_on = cl_qual;
		if (flt_on)
		begin
			out_h_d = io_q[IO_FAULT_PIN_STATES_H];
			out_l_d = io_q[IO_FAULT_PIN_STATES_L];
		end
		else if (cl_on)
		begin
			out_h_d = io_q[IO_CURRENT_LIMIT_PIN_STATES_H];
			out_l_d = io_q[IO_CURRENT_LIMIT_PIN_STATES_L];
		end
		else
		begin
			out_h_d = ovr_q[3] ? ovr_q[1] : pre_h;
			out_l_d = ovr_q[2] ? ovr_q[0] : pre_l;
		end
		trig_d_o = local_tb_i && (tb_count_i == trig_q);
	end

	// Protection state
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_m_q <= '0;
			src_s_q <= '0;
			ovr_q <= '0;
			prev_h_q <= 1'b0;
			prev_l_q <= 1'b0;
			cnt_q <= '0;
			latch_q <= 1'b0;
			out_h_q <= 1'b0;
			out_l_q <= 1'b0;
			trig_q_o <= 1'b0;
			fault_active_o <= 1'b0;
			limit_active_o <= 1'b0;
		end
		else if (ce_i)
		begin
			src_m_q <= prot_src_i;
			src_s_q <= src_m_q;
			ovr_q <= ovr_d;
			prev_h_q <= pre_h;
			prev_l_q <= pre_l;
			cnt_q <= cnt_d;
			latch_q <= latch_d;
			out_h_q <= out_h_d;
			out_l_q <= out_l_d;
			trig_q_o <= trig_d_o;
			fault_active_o <= flt_on;
			limit_active_o <= cl_on;
		end
	end

	assign high_side_output_o = out_h_q;
	assign low_side_output_o = out_l_q;
	assign adc_trigger_o = trig_q_o;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_key_a;
		ce_i && wr_i && addr_i == OFS_UNLOCK && wdata_i == KEY_A;
	endsequence
	sequence s_key_b;
		ce_i && wr_i && addr_i == OFS_UNLOCK && wdata_i == KEY_B;
	endsequence

	a_unlock_seq: assert property (s_key_a ##1 s_key_b |=> ul_q == UL_OPEN)
		else $error("unlock sequence did not open");
	a_lock_reject: assert property (ce_i && wr_i && addr_i == OFS_FCL
		&& pwm_write_lock_cfg_i && ul_q != UL_OPEN |=> fcl_q == $past(fcl_q))
		else $error("locked write changed fault control");
	a_fault_force: assert property (ce_i && flt_on |=> high_side_output_o == $past(io_q[IO_FAULT_PIN_STATES_H])
		&& low_side_output_o == $past(io_q[IO_FAULT_PIN_STATES_L]))
		else $error("fault data not driven");
	a_limit_force: assert property (ce_i && !flt_on && cl_on
		|=> high_side_output_o == $past(io_q[IO_CURRENT_LIMIT_PIN_STATES_H]))
		else $error("limit data not driven");
	a_swap_route: assert property (ce_i && !flt_on && !cl_on && !ovr_q[3] && io_q[IO_SWAP]
		|=> high_side_output_o == $past(gen_low_i))
		else $error("swap not applied");
	a_trig_match: assert property (ce_i && local_tb_i && tb_count_i == trig_q
		|=> adc_trigger_o)
		else $error("trigger missed");
	a_fault_off: assert property (fmode[1] |-> !flt_qual)
		else $error("disabled fault acted");
	a_latch_hold: assert property (ce_i && flt_qual && fmode == FLT_LATCHED
		##1 (ce_i && !fcl_wr && fmode == FLT_LATCHED) |=> fault_active_o && latch_q)
		else $error("latched fault released");
	a_leb_mask: assert property (cnt_q != '0 && leb_q[LEB_FLTEN] |-> !flt_qual)
		else $error("blanked fault passed");
	a_ovr_sync: assert property (ce_i && io_q[IO_OVERRIDE_SYNC_SEL] && !period_start_i
		|=> ovr_q == $past(ovr_q))
		else $error("override moved off boundary");
endmodule // pwm_prot_out

// ===== rtl/pwm_prot_pkg.sv
// Constants and source decode shared by the PWM protection and output block
package pwm_prot_pkg;
	localparam int AW = 4;
	localparam int DW = 16;
	localparam int SRC_W = 14;
	// Register word indices
	localparam logic [AW-1:0] OFS_IO = 4'h0;
	localparam logic [AW-1:0] OFS_TRIG = 4'h1;
	localparam logic [AW-1:0] OFS_FCL = 4'h2;
	localparam logic [AW-1:0] OFS_LEB = 4'h3;
	localparam logic [AW-1:0] OFS_DLY = 4'h4;
	localparam logic [AW-1:0] OFS_AUX = 4'h5;
	localparam logic [AW-1:0] OFS_UNLOCK = 4'h6;
	localparam logic [AW-1:0] OFS_STAT = 4'h7;
	// Reset values and implemented-bit masks
	localparam logic [DW-1:0] IO_RST = 16'hc000;
	localparam logic [DW-1:0] FCL_RST = 16'h00f8;
	localparam logic [DW-1:0] ZERO_RST = 16'h0000;
	localparam logic [DW-1:0] FCL_MASK = 16'h7fff;
	localparam logic [DW-1:0] LEB_MASK = 16'hfc3f;
	localparam logic [DW-1:0] DLY_MASK = 16'h0fff;
	localparam logic [DW-1:0] AUX_MASK = 16'h0f3f;
	localparam logic [DW-1:0] KEY_A = 16'h55aa;
	localparam logic [DW-1:0] KEY_B = 16'haa55;
	// I/O control fields
	localparam int IO_OVRENH = 9;
	localparam int IO_OVRENL = 8;
	localparam int IO_OVERRIDE_PIN_STATES_H = 7;
	localparam int IO_OVERRIDE_PIN_STATES_L = 6;
	localparam int IO_FAULT_PIN_STATES_H = 5;
	localparam int IO_FAULT_PIN_STATES_L = 4;
	localparam int IO_CURRENT_LIMIT_PIN_STATES_H = 3;
	localparam int IO_CURRENT_LIMIT_PIN_STATES_L = 2;
	localparam int IO_SWAP = 1;
	localparam int IO_OVERRIDE_SYNC_SEL = 0;
	// Fault and current-limit control fields
	localparam int FCL_CURRENT_LIMIT_SOURCE_SEL = 10;
	localparam int FCL_CURRENT_LIMIT_POLARITY = 9;
	localparam int FCL_CURRENT_LIMIT_ENABLE = 8;
	localparam int FCL_FAULT_SOURCE_SEL = 3;
	localparam int FCL_FAULT_POLARITY = 2;
	localparam int FCL_FAULT_MODE_SEL = 0;
	// Edge blanking control fields
	localparam int LEB_PHR = 15;
	localparam int LEB_PHF = 14;
	localparam int LEB_PLR = 13;
	localparam int LEB_PLF = 12;
	localparam int LEB_FLTEN = 11;
	localparam int LEB_CLEN = 10;
	localparam int LEB_BCH = 5;
	localparam int LEB_BCL = 4;
	localparam int LEB_BLANK_WHEN_HI_OUT_HIGH = 3;
	localparam int LEB_BLANK_WHEN_HI_OUT_LOW = 2;
	localparam int LEB_BLANK_WHEN_LO_OUT_HIGH = 1;
	localparam int LEB_BLANK_WHEN_LO_OUT_LOW = 0;
	localparam int AUX_STATE_BLANK_SOURCE_SEL = 8;
	localparam int LEB_W = 12;
	// Source codes and source vector layout
	localparam logic [4:0] SRC_LAST_FAULT = 5'h07;
	localparam logic [4:0] SRC_LAST_COMP = 5'h0c;
	localparam logic [4:0] SRC_FAULT32 = 5'h1f;
	localparam int VEC_FAULT32 = 13;
	localparam logic [3:0] BLANK_NONE = 4'h0;
	localparam logic [3:0] BLANK_LAST = 4'h3;
	// Fault modes
	localparam logic [1:0] FLT_LATCHED = 2'h0;
	localparam logic [1:0] FLT_CYCLE = 2'h1;

	// Pick one protection source; reserved codes connect nothing
	function automatic logic src_pick(input logic [4:0] code, input logic [SRC_W-1:0] vec);
		logic r;
		r = 1'b0;
		if (code <= SRC_LAST_COMP)
			r = vec[code[3:0]];
		else if (code == SRC_FAULT32)
			r = vec[VEC_FAULT32];
		return r;
	endfunction
endpackage

// ===== tb/fault_src_model.sv
// Behavioural far side: power-stage fault and comparator lines
module fault_src_model
	import pwm_prot_pkg::*;
(
	input wire logic clk_i,
	input wire logic [SRC_W-1:0] want_i,
	output logic [SRC_W-1:0] prot_src_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines move off the edge, unrelated to the sampling instant
	initial prot_src_o = '0;
	always @(posedge clk_i)
		prot_src_o <= #3 want_i;
endmodule // fault_src_model

// ===== tb/tb_pwm_prot_out.sv
// Self-checking bench for the PWM protection and output block
module tb_pwm_prot_out;
	import pwm_prot_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [AW-1:0] addr_i = '0;
	logic [DW-1:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [DW-1:0] rdata_o;
	logic lock = 1'b0;
	logic gh = 1'b1;
	logic gl = 1'b0;
	logic local_tb = 1'b0;
	logic ps = 1'b0;
	logic [2:0] peer = 3'h0;
	logic [DW-1:0] cnt = 16'h0000;
	logic [SRC_W-1:0] want = '0;
	logic [SRC_W-1:0] src;
	logic ho, lo, trg, fa, la;
	logic [DW-1:0] v;
	int error_cnt = 0;
	int tests_run = 0;
	// ----------------------------------------
	// Clock, partner and design
	// ----------------------------------------
	initial forever #4 clk_i = ~clk_i;
	fault_src_model fault_src_model_i (.clk_i(clk_i), .want_i(want), .prot_src_o(src));
	pwm_prot_out pwm_prot_out_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.pwm_write_lock_cfg_i(lock), .gen_high_i(gh), .gen_low_i(gl),
		.period_start_i(ps), .local_tb_i(local_tb), .tb_count_i(cnt),
		.peer_high_i(peer), .prot_src_i(src), .high_side_output_o(ho),
		.low_side_output_o(lo), .adc_trigger_o(trg), .fault_active_o(fa),
		.limit_active_o(la));
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		// Read data stand in the cycle after the strobe; take them at its closing edge
		@(posedge clk_i);
		v = rdata_o;
	endtask
	task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Let protection pass its synchroniser, then look at pins and flags
	task automatic pins(input logic [3:0] e);
		repeat (6) @(posedge clk_i);
		chk("pins", {12'h0, e}, {12'h0, fa, la, ho, lo});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog well past the few hundred cycles of the sequence
	initial
	begin
		#50us;
		error_cnt++;
		report_and_stop();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(OFS_IO);
		chk("io reset", IO_RST, v);
		rd(OFS_FCL);
		chk("fcl reset", FCL_RST, v);
		rd(4'h8);
		chk("unmapped", 16'h0000, v);
		// Locked write dropped, unlocked write taken
		lock <= 1'b1;
		wr(OFS_FCL, 16'h0011);
		rd(OFS_FCL);
		chk("locked fcl", FCL_RST, v);
		wr(OFS_UNLOCK, KEY_A);
		wr(OFS_UNLOCK, KEY_B);
		wr(OFS_FCL, 16'h0003);
		rd(OFS_FCL);
		chk("unlocked fcl", 16'h0003, v);
		lock <= 1'b0;
		// Compare match gives a trigger one cycle later
		wr(OFS_TRIG, 16'h0010);
		local_tb <= 1'b1;
		cnt <= 16'h0010;
		@(posedge clk_i);
		cnt <= 16'h0011;
		@(posedge clk_i);
		chk("trigger", 16'h0001, {15'h0, trg});
		@(posedge clk_i);
		chk("no trigger", 16'h0000, {15'h0, trg});
		// Swap exchanges the generator signals
		pins(4'h2);
		wr(OFS_IO, 16'hc002);
		pins(4'h1);
		// Cycle-by-cycle fault on fault 3, data high=1 low=0
		gh <= 1'b0;
		gl <= 1'b1;
		wr(OFS_IO, 16'hc020);
		wr(OFS_FCL, 16'h0011);
		want <= 14'h0004;
		pins(4'ha);
		want <= 14'h0000;
		pins(4'h1);
		// Latched fault stays after the input drops
		wr(OFS_FCL, 16'h0010);
		want <= 14'h0004;
		pins(4'ha);
		want <= 14'h0000;
		pins(4'ha);
		// Reserved code connects nothing
		wr(OFS_FCL, 16'h0069);
		want <= 14'h3fff;
		pins(4'h1);
		// Active-low comparator 1 as limit, fault disabled, limit data high=1
		wr(OFS_IO, 16'hc008);
		wr(OFS_FCL, 16'h2303);
		want <= 14'h3eff;
		pins(4'h6);
		wr(OFS_FCL, 16'h2203);
		pins(4'h1);
		// Fault beats limit: fault data 01, limit data 10, generator 11
		gh <= 1'b1;
		wr(OFS_IO, 16'hc018);
		wr(OFS_FCL, 16'h2301);
		pins(4'hd);
		want <= 14'h3fff;
		pins(4'h9);
		// Override held until the time base boundary
		wr(OFS_FCL, 16'h0003);
		want <= 14'h0000;
		wr(OFS_IO, 16'hc301);
		pins(4'h3);
		ps <= 1'b1;
		@(posedge clk_i);
		ps <= 1'b0;
		pins(4'h0);
		// State blanking on own output and on a peer output
		wr(OFS_IO, 16'hc000);
		wr(OFS_LEB, 16'h0008);
		wr(OFS_FCL, 16'h0001);
		want <= 14'h0001;
		pins(4'h3);
		wr(OFS_LEB, 16'h0004);
		pins(4'h8);
		wr(OFS_AUX, 16'h0200);
		wr(OFS_LEB, 16'h0020);
		peer <= 3'h2;
		pins(4'h3);
		peer <= 3'h0;
		pins(4'h8);
		wr(OFS_AUX, 16'h0400);
		peer <= 3'h7;
		pins(4'h8);
		// Rising edge starts blanking, which masks the fault until the delay runs out
		wr(OFS_AUX, 16'h0000);
		wr(OFS_LEB, 16'h8800);
		wr(OFS_DLY, 16'h0040);
		gh <= 1'b0;
		pins(4'h8);
		gh <= 1'b1;
		pins(4'h3);
		rd(OFS_STAT);
		chk("blank status", 16'h0004, v);
		repeat (70) @(posedge clk_i);
		pins(4'h8);
		report_and_stop();
	end
endmodule // tb_pwm_prot_out
